// file: dom_pkg.sv
// Purpose: Shared constants and types for the detector option/test menu block
// Assumes: 40 MHz system clock, synchronous active-high reset
// Notes:   Register offsets are byte addresses on a classic Wishbone slave
//
// Notes on behaviour
// - Option menu idles ten seconds, back home
// - Under-range mark shown below minus ten percent
// - Under-range marking powers up off
// - Raw-data display toggle, test only, default off
// - Zero-skip band zero to twenty percent
// - Span-skip band zero to twenty percent
// - Emergency timeout ends checkup after thirty minutes
// - Completion message two seconds, then home
// - Confirm stores and advances; reset returns head
// - Menus entered only after correct password
// - Test menu idles ten seconds, back home
// - Test concentration set by keys drives alarms
// - Trouble relay test toggle, default off
// - Alarm relay test toggle, same navigation
// - Forced loop maps 0..100 to 4..20 mA
// - Forced loop off keeps three milliamps
// - Reset in test submenus returns test head, except from test concentration, which returns home
// - Serial menu idles ten seconds, back home
// - Station number default one, one step per press
// - Parity code default one: none, even, odd
// - Maintenance picks input or output calibration
package dom_pkg;

   // Timing
   localparam int unsigned CLK_HZ          = 40_000_000;  // System clock rate
   localparam int unsigned IDLE_SEC        = 10;          // Menu inactivity time
   localparam int unsigned END_SEC         = 2;           // Completion message time
   localparam int unsigned CHECKUP_MIN     = 30;          // Emergency checkup limit
   localparam int unsigned DEBOUNCE_MS     = 20;          // Key settle time
   localparam int unsigned IDLE_CYC        = CLK_HZ * IDLE_SEC;
   localparam int unsigned END_CYC         = CLK_HZ * END_SEC;
   localparam longint unsigned CHECKUP_CYC = longint'(CLK_HZ) * 64'd60 * CHECKUP_MIN;
   localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;

   // Value limits
   localparam logic [4:0]  SKIP_MAX        = 5'h14;   // 20 percent
   localparam logic [6:0]  LOOP_MAX        = 7'h64;   // Display 100
   localparam logic [6:0]  LOOP_START      = 7'h64;   // Forced loop starts at 100
   localparam logic [1:0]  PARITY_MAX      = 2'h2;    // Odd
   localparam logic [1:0]  PARITY_RST      = 2'h1;    // Even
   localparam logic [7:0]  STATION_RST     = 8'h01;
   localparam logic [7:0]  STATION_MAX     = 8'hf7;
   localparam logic [15:0] PASSWORD_RST    = 16'h0000;
   localparam logic [15:0] UNDER_LIMIT_PCT = 16'hfff6; // Minus ten percent, signed
   // Loop current in units of 0.1 mA
   localparam logic [7:0]  LOOP_BASE_TENTH = 8'h1e;   // 3.0 mA
   localparam logic [7:0]  LOOP_ZERO_TENTH = 8'h28;   // 4.0 mA
   localparam logic [7:0]  LOOP_SPAN_TENTH = 8'ha0;   // 16.0 mA span

   // Wishbone register byte offsets
   localparam logic [7:0] REG_OPTION   = 8'h00; // [0]under [1]raw [2]emerg [12:8]zskip [20:16]sskip
   localparam logic [7:0] REG_TEST     = 8'h04; // [0]trouble [1]alarm [2]loop_on [14:8]loop_val
   localparam logic [7:0] REG_SERIAL   = 8'h08; // [7:0]station [9:8]parity
   localparam logic [7:0] REG_PASSWORD = 8'h0c; // [15:0] write-only password
   localparam logic [7:0] REG_STATUS   = 8'h10; // [4:0]state [8]pw_ok [9]checkup [15:10]zero
   localparam logic [7:0] REG_TESTCONC = 8'h14; // [15:0]test concentration

   // Field positions
   localparam int OPT_UNDER   = 0;
   localparam int OPT_RAW     = 1;
   localparam int OPT_EMERG   = 2;
   localparam int OPT_ZSKIP   = 8;
   localparam int OPT_SSKIP   = 16;
   localparam int TST_TROUBLE = 0;
   localparam int TST_ALARM   = 1;
   localparam int TST_LOOP    = 2;
   localparam int TST_LVAL    = 8;
   localparam int SER_PARITY  = 8;
   localparam int STS_PWOK    = 8;
   localparam int STS_CHECK   = 9;

   // Menu states
   typedef enum logic [4:0] {
      MS_HOME, MS_SELECT,
      MS_OPT_HEAD, MS_OPT_RAW, MS_OPT_UNDER, MS_OPT_ZSKIP, MS_OPT_SSKIP, MS_OPT_EMERG,
      MS_TST_HEAD, MS_TST_CONC, MS_TST_TROUBLE, MS_TST_ALARM, MS_TST_LOOP_ON, MS_TST_LOOP_VAL,
      MS_SER_HEAD, MS_SER_STATION, MS_SER_PARITY,
      MS_MNT_PICK, MS_MNT_IN, MS_MNT_OUT,
      MS_END
   } dom_state_t;

   // Top-level menu choice at the select step
   typedef enum logic [1:0] {
      MC_OPTION, MC_TEST, MC_SERIAL, MC_MAINT
   } dom_menu_t;

endpackage : dom_pkg

// file: dom_key_debounce.sv
// Purpose: Debounce one push switch and emit a single press pulse
// Assumes: Switch level is synchronous to clk, active high when pressed
// Notes:   Pulse fires once per settled press edge
`timescale 1ns/100ps
module dom_key_debounce
   import dom_pkg::*;
#(
   parameter int unsigned SETTLE = DEBOUNCE_CYC
)(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic key_raw,
   output logic      key_level,
   output logic      key_press
);

   // Whole state of the debouncer
   typedef struct packed {
      logic        stable;   // Accepted key level
      logic [19:0] count;    // Settle counter
      logic        press;    // One-cycle press pulse
   } dom_deb_t;

   dom_deb_t s_r;
   dom_deb_t s_nxt;

   // Count while raw level differs from accepted level
   always_comb
   begin
      s_nxt       = s_r;
      s_nxt.press = 1'b0;
      if (key_raw == s_r.stable)
      begin
         s_nxt.count = 20'h00000;
      end
      else if (s_r.count >= 20'(SETTLE - 1))
      begin
         s_nxt.stable = key_raw;
         s_nxt.count  = 20'h00000;
         s_nxt.press  = key_raw;
      end
      else
      begin
         s_nxt.count = s_r.count + 20'h00001;
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (reset)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign key_level = s_r.stable;
   assign key_press = s_r.press;

endmodule : dom_key_debounce

// file: dom_menu.sv
// Purpose: Front-panel option/test/serial/maintenance menu controller
// Assumes: Four push switches synchronous to clk; classic Wishbone slave
// Notes:   Option and serial settings also writable from software; keys win on same cycle
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module dom_menu
   import dom_pkg::*;
#(
   parameter int unsigned       DEB_CYC  = DEBOUNCE_CYC,  // Key settle time
   parameter int unsigned       IDLE_LIM = IDLE_CYC,      // Menu inactivity
   parameter int unsigned       END_LIM  = END_CYC,       // Completion message
   parameter longint unsigned   CHK_LIM  = CHECKUP_CYC    // Emergency checkup
)(
   input  wire logic        clk,
   input  wire logic        reset,
   // Front panel keys, high when pressed
   input  wire logic        confirm_key,
   input  wire logic        up_key,
   input  wire logic        down_key,
   input  wire logic        reset_key,
   // Measurement and checkup request
   input  wire logic [15:0] sensor_value,
   input  wire logic [15:0] sensor_raw,
   input  wire logic [15:0] high_scale,
   input  wire logic        checkup_start,
   // Display and outputs
   output logic [4:0]       menu_state,
   output logic [15:0]      segment_display,
   output logic             under_mark,
   output logic [15:0]      alarm_value,
   output logic             trouble_relay_test,
   output logic             alarm_relay_test,
   output logic [7:0]       loop_tenth_ma,
   output logic             checkup_active,
   output logic             maint_cal_in,
   output logic             maint_cal_out,
   output logic [7:0]       station_number,
   output logic [1:0]       parity_item,
   // Wishbone slave
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             err_o
);

   // Whole state of the menu block
   typedef struct packed {
      dom_state_t  st;          // Menu position
      dom_menu_t   pick;        // Selected menu at select step
      logic        maint_out;   // Maintenance pick: output cal
      logic        under_on;    // Under-range marking
      logic        raw_on;      // Raw-data display
      logic        emerg_on;    // Emergency checkup timeout
      logic [4:0]  zskip;       // Zero-skip percent
      logic [4:0]  sskip;       // Span-skip percent
      logic        trouble_on;  // Trouble relay test
      logic        alarm_on;    // Alarm relay test
      logic        loop_on;     // Forced loop output
      logic [6:0]  loop_val;    // Forced loop display value
      logic [15:0] test_conc;   // Simulated concentration
      logic [7:0]  station;     // Serial station number
      logic [1:0]  parity;      // Parity code
      logic [15:0] password;    // Required password
      logic        pw_ok;       // Password accepted
      logic [29:0] idle_cnt;    // Inactivity timer
      logic [26:0] end_cnt;     // Completion message timer
      logic [36:0] chk_cnt;     // Checkup timer
      logic        checkup;     // Checkup mode running
      logic [31:0] rdata;       // Bus read data
      logic        ack;         // Bus acknowledge
      logic        err;         // Bus error
   } dom_core_t;

   dom_core_t s_r;
   dom_core_t s_nxt;

   logic p_conf;    // Confirm press pulse
   logic p_up;      // Up press pulse
   logic p_down;    // Down press pulse
   logic p_rst;     // Reset press pulse

   // One debouncer per key
   dom_key_debounce #(.SETTLE(DEB_CYC)) u_conf (
      .clk       (clk),
      .reset     (reset),
      .key_raw   (confirm_key),
      .key_level (),
      .key_press (p_conf)
   );
   dom_key_debounce #(.SETTLE(DEB_CYC)) u_up (
      .clk       (clk),
      .reset     (reset),
      .key_raw   (up_key),
      .key_level (),
      .key_press (p_up)
   );
   dom_key_debounce #(.SETTLE(DEB_CYC)) u_down (
      .clk       (clk),
      .reset     (reset),
      .key_raw   (down_key),
      .key_level (),
      .key_press (p_down)
   );
   dom_key_debounce #(.SETTLE(DEB_CYC)) u_rst (
      .clk       (clk),
      .reset     (reset),
      .key_raw   (reset_key),
      .key_level (),
      .key_press (p_rst)
   );

   // Saturating step within 0..max on up/down press
   function automatic logic [7:0] step8(input logic [7:0] v, input logic [7:0] max,
                                        input logic up, input logic dn);
      logic [7:0] r;
      r = v;
      if (up && v < max)
         r = v + 8'h01;
      else if (dn && v != 8'h00)
         r = v - 8'h01;
      return r;
   endfunction : step8

   // Percent of high scale, truncated
   function automatic logic [15:0] pct_of(input logic [15:0] hs, input logic [4:0] pct);
      logic [22:0] p;
      p = 23'(hs) * 23'(pct);
      return 16'(p / 23'd100);
   endfunction : pct_of

   logic        any_key;      // Any press this cycle
   logic        in_option;    // Option menu states
   logic        in_test;      // Test menu states
   logic        in_serial;    // Serial menu states
   logic        in_menu;      // Any timed menu
   logic [15:0] proc_value;   // Skip bands applied
   logic [15:0] shown;        // Concentration to display
   logic [15:0] zband;        // Zero-skip threshold
   logic [15:0] sband;        // Span-skip threshold
   logic        bus_req;      // New bus cycle
   logic [7:0]  station_nxt;  // Station after key step

   assign any_key   = p_conf | p_up | p_down | p_rst;
   assign in_option = s_r.st inside {MS_OPT_HEAD, MS_OPT_RAW, MS_OPT_UNDER, MS_OPT_ZSKIP,
                                     MS_OPT_SSKIP, MS_OPT_EMERG};
   assign in_test   = s_r.st inside {MS_TST_HEAD, MS_TST_CONC, MS_TST_TROUBLE, MS_TST_ALARM,
                                     MS_TST_LOOP_ON, MS_TST_LOOP_VAL};
   assign in_serial = s_r.st inside {MS_SER_HEAD, MS_SER_STATION, MS_SER_PARITY};
   assign in_menu   = in_option | in_test | in_serial;
   assign bus_req   = cyc_i & stb_i & ~s_r.ack & ~s_r.err;
   assign station_nxt = step8(s_r.station, STATION_MAX, p_up, p_down);

   // Skip bands: near zero forced to zero, near top forced to top
   always_comb
   begin
      zband = pct_of(high_scale, s_r.zskip);
      sband = pct_of(high_scale, s_r.sskip);
      proc_value = s_r.test_conc;
      if (!in_test)
         proc_value = sensor_value;
      if (!proc_value[15] && proc_value < zband)
         proc_value = 16'h0000;
      else if (!proc_value[15] && sband != 16'h0000 && proc_value + sband >= high_scale)
         proc_value = high_scale;
      shown = s_r.raw_on ? sensor_raw : proc_value;
   end

   // Menu, timers and bus
   always_comb
   begin
      s_nxt       = s_r;
      s_nxt.ack   = 1'b0;
      s_nxt.err   = 1'b0;

      // Inactivity timers
      if (any_key || !in_menu)
         s_nxt.idle_cnt = 30'h00000000;
      else
         s_nxt.idle_cnt = s_r.idle_cnt + 30'h00000001;
      if (in_menu && s_r.idle_cnt >= 30'(IDLE_LIM - 1))
      begin
         s_nxt.st    = MS_HOME;
         s_nxt.pw_ok = 1'b0;
      end

      // Checkup mode with optional emergency timeout
      if (checkup_start)
      begin
         s_nxt.checkup = 1'b1;
         s_nxt.chk_cnt = 37'h0;
      end
      else if (s_r.checkup && s_r.emerg_on)
      begin
         s_nxt.chk_cnt = s_r.chk_cnt + 37'h1;
         if (s_r.chk_cnt >= 37'(CHK_LIM - 1))
            s_nxt.checkup = 1'b0;
      end

      // Key-driven menu walk
      case (s_r.st)
         MS_HOME:
         begin
            if (p_conf && s_r.pw_ok)
               s_nxt.st = MS_SELECT;
         end
         MS_SELECT:
         begin
            if (p_up)
               s_nxt.pick = dom_menu_t'(s_r.pick + 2'h1);
            else if (p_down)
               s_nxt.pick = dom_menu_t'(s_r.pick - 2'h1);
            else if (p_rst)
               s_nxt.st = MS_HOME;
            else if (p_conf)
            begin
               case (s_r.pick)
                  MC_OPTION: s_nxt.st = MS_OPT_HEAD;
                  MC_TEST:   s_nxt.st = MS_TST_HEAD;
                  MC_SERIAL: s_nxt.st = MS_SER_HEAD;
                  default:   s_nxt.st = MS_MNT_PICK;
               endcase
            end
         end
         MS_OPT_HEAD, MS_TST_HEAD, MS_SER_HEAD:
         begin
            if (p_rst)
               s_nxt.st = MS_HOME;
            else if (p_conf)
               s_nxt.st = dom_state_t'(s_r.st + 5'h01);
         end
         MS_OPT_RAW, MS_OPT_UNDER, MS_OPT_EMERG:
         begin
            if (p_up || p_down)
            begin
               if (s_r.st == MS_OPT_RAW)
                  s_nxt.raw_on = ~s_r.raw_on;
               else if (s_r.st == MS_OPT_UNDER)
                  s_nxt.under_on = ~s_r.under_on;
               else
                  s_nxt.emerg_on = ~s_r.emerg_on;
            end
            else if (p_rst)
               s_nxt.st = MS_OPT_HEAD;
            else if (p_conf)
               s_nxt.st = (s_r.st == MS_OPT_EMERG) ? MS_END : dom_state_t'(s_r.st + 5'h01);
         end
         MS_OPT_ZSKIP, MS_OPT_SSKIP:
         begin
            if (s_r.st == MS_OPT_ZSKIP)
               s_nxt.zskip = 5'(step8(8'(s_r.zskip), 8'(SKIP_MAX), p_up, p_down));
            else
               s_nxt.sskip = 5'(step8(8'(s_r.sskip), 8'(SKIP_MAX), p_up, p_down));
            if (p_rst)
               s_nxt.st = MS_OPT_HEAD;
            else if (p_conf)
               s_nxt.st = dom_state_t'(s_r.st + 5'h01);
         end
         MS_TST_CONC:
         begin
            if (p_up)
               s_nxt.test_conc = s_r.test_conc + 16'h0001;
            else if (p_down)
               s_nxt.test_conc = s_r.test_conc - 16'h0001;
            else if (p_rst)
               s_nxt.st = MS_HOME;
            else if (p_conf)
               s_nxt.st = MS_TST_TROUBLE;
         end
         MS_TST_TROUBLE, MS_TST_ALARM, MS_TST_LOOP_ON:
         begin
            if (p_up || p_down)
            begin
               if (s_r.st == MS_TST_TROUBLE)
                  s_nxt.trouble_on = ~s_r.trouble_on;
               else if (s_r.st == MS_TST_ALARM)
                  s_nxt.alarm_on = ~s_r.alarm_on;
               else
                  s_nxt.loop_on = ~s_r.loop_on;
            end
            else if (p_rst)
               s_nxt.st = MS_TST_HEAD;
            else if (p_conf)
            begin
               s_nxt.st = dom_state_t'(s_r.st + 5'h01);
               if (s_r.st == MS_TST_LOOP_ON)
                  s_nxt.loop_val = s_r.loop_on ? LOOP_START : 7'h00;
            end
         end
         MS_TST_LOOP_VAL:
         begin
            s_nxt.loop_val = 7'(step8(8'(s_r.loop_val), 8'(LOOP_MAX), p_up, p_down));
            if (p_rst || p_conf)
               s_nxt.st = MS_TST_HEAD;
         end
         MS_SER_STATION:
         begin
            s_nxt.station = station_nxt;
            if (p_rst)
               s_nxt.st = MS_SER_HEAD;
            else if (p_conf)
               s_nxt.st = MS_SER_PARITY;
         end
         MS_SER_PARITY:
         begin
            s_nxt.parity = 2'(step8(8'(s_r.parity), 8'(PARITY_MAX), p_up, p_down));
            if (p_rst)
               s_nxt.st = MS_SER_HEAD;
            else if (p_conf)
               s_nxt.st = MS_END;
         end
         MS_MNT_PICK:
         begin
            if (p_up || p_down)
               s_nxt.maint_out = ~s_r.maint_out;
            else if (p_rst)
               s_nxt.st = MS_HOME;
            else if (p_conf)
               s_nxt.st = s_r.maint_out ? MS_MNT_OUT : MS_MNT_IN;
         end
         MS_MNT_IN, MS_MNT_OUT:
         begin
            if (p_rst)
               s_nxt.st = MS_HOME;   // Later calibration steps live elsewhere
         end
         MS_END:
         begin
            s_nxt.end_cnt = s_r.end_cnt + 27'h1;
            if (s_r.end_cnt >= 27'(END_LIM - 1))
            begin
               s_nxt.st      = MS_HOME;
               s_nxt.end_cnt = 27'h0;
               s_nxt.pw_ok   = 1'b0;
            end
         end
         default:
            s_nxt.st = MS_HOME;
      endcase

      // Wishbone slave: one-cycle answer, ack drops next cycle
      if (bus_req)
      begin
         s_nxt.rdata = 32'h00000000;
         s_nxt.ack   = 1'b1;
         case (adr_i)
            REG_OPTION:
            begin
               s_nxt.rdata = {11'h000, s_r.sskip, 3'h0, s_r.zskip, 5'h00,
                              s_r.emerg_on, s_r.raw_on, s_r.under_on};
               if (we_i && sel_i[0] && !any_key)
               begin
                  s_nxt.under_on = dat_i[OPT_UNDER];
                  s_nxt.raw_on   = dat_i[OPT_RAW];
                  s_nxt.emerg_on = dat_i[OPT_EMERG];
               end
               if (we_i && sel_i[1] && !any_key && dat_i[OPT_ZSKIP +: 5] <= SKIP_MAX)
                  s_nxt.zskip = dat_i[OPT_ZSKIP +: 5];
               if (we_i && sel_i[2] && !any_key && dat_i[OPT_SSKIP +: 5] <= SKIP_MAX)
                  s_nxt.sskip = dat_i[OPT_SSKIP +: 5];
            end
            REG_TEST:
               s_nxt.rdata = {17'h00000, s_r.loop_val, 5'h00,
                              s_r.loop_on, s_r.alarm_on, s_r.trouble_on};
            REG_SERIAL:
            begin
               s_nxt.rdata = {22'h000000, s_r.parity, s_r.station};
               if (we_i && sel_i[0] && !any_key)
                  s_nxt.station = dat_i[7:0];
               if (we_i && sel_i[1] && !any_key && dat_i[SER_PARITY +: 2] <= PARITY_MAX)
                  s_nxt.parity = dat_i[SER_PARITY +: 2];
            end
            REG_PASSWORD:
            begin
               if (we_i && sel_i[1:0] == 2'h3)
                  s_nxt.pw_ok = (dat_i[15:0] == s_r.password);
            end
            REG_STATUS:
               s_nxt.rdata = {22'h000000, s_r.checkup, s_r.pw_ok, 3'h0, s_r.st};
            REG_TESTCONC:
               s_nxt.rdata = {16'h0000, s_r.test_conc};
            default:
            begin
               s_nxt.ack = 1'b0;
               s_nxt.err = 1'b1;   // Unmapped address
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_r          <= '0;
         s_r.st       <= MS_HOME;
         s_r.under_on <= 1'b0;
         s_r.station  <= STATION_RST;
         s_r.parity   <= PARITY_RST;
         s_r.password <= PASSWORD_RST;
      end
      else
         s_r <= s_nxt;
   end

   // Outputs
   assign menu_state         = s_r.st;
   assign segment_display    = (s_r.st == MS_TST_LOOP_VAL) ? 16'(s_r.loop_val) : shown;
   assign under_mark         = s_r.under_on && $signed(shown) < $signed(16'h0000 - pct_of(high_scale, 5'h0a))
                               && shown[15];
   assign alarm_value        = proc_value;
   assign trouble_relay_test = in_test & s_r.trouble_on;
   assign alarm_relay_test   = in_test & s_r.alarm_on;
   assign loop_tenth_ma      = (in_test && s_r.loop_on)
                               ? 8'(LOOP_ZERO_TENTH + 8'((16'(s_r.loop_val) * 16'(LOOP_SPAN_TENTH)) / 16'd100))
                               : LOOP_BASE_TENTH;
   assign checkup_active     = s_r.checkup;
   assign maint_cal_in       = (s_r.st == MS_MNT_IN);
   assign maint_cal_out      = (s_r.st == MS_MNT_OUT);
   assign station_number     = s_r.station;
   assign parity_item        = s_r.parity;
   assign dat_o              = s_r.rdata;
   assign ack_o              = s_r.ack;
   assign err_o              = s_r.err;

endmodule : dom_menu

// file: dom_op.sv
// Purpose: Operator pressing one front-panel key at a time
// Assumes: Hold and rest both outlast the key settle time
// Notes:   Keys rest low between presses
`timescale 1ns/100ps
module dom_op (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [1:0] k,
   output logic [3:0]      keys,
   output logic            busy
);
   logic [4:0] cnt_r = '0; // Press then rest phase
   logic [1:0] k_r;        // Key being pressed
   always @(posedge clk)
      if (go && cnt_r == 5'h0) {k_r, cnt_r} <= {k, 5'h14};
      else if (cnt_r != 5'h0) cnt_r <= cnt_r - 5'h1;
   assign keys = (cnt_r > 5'h0a) ? (4'h1 << k_r) : 4'h0;
   assign busy = go || cnt_r != 5'h0;
endmodule : dom_op

// file: dom_props.sv
// Purpose: Port assertions for the menu block
// Assumes: IDLE_LIM 200, END_LIM 50
// Notes:   Quiet count restarts on any key or state change
`timescale 1ns/100ps
module dom_props
   import dom_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       confirm_key,
   input wire logic       up_key,
   input wire logic       down_key,
   input wire logic       reset_key,
   input wire logic [4:0] menu_state,
   input wire logic       trouble_relay_test,
   input wire logic       alarm_relay_test,
   input wire logic [7:0] loop_tenth_ma,
   input wire logic       maint_cal_in,
   input wire logic       maint_cal_out
);
   logic [8:0] idle_r; // Quiet cycles
   wire logic  tst = menu_state inside {[MS_TST_HEAD:MS_TST_LOOP_VAL]};
   always_ff @(posedge clk)
      if (reset || $changed(menu_state) || confirm_key || up_key || down_key || reset_key) idle_r <= '0;
      else idle_r <= idle_r + 9'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_idle; menu_state inside {[MS_OPT_HEAD:MS_SER_PARITY]} |-> idle_r < 9'd205; endproperty
   a_idle: assert property (p_idle) else $error("menu idle too long");
   property p_end; $rose(menu_state == MS_END) |-> ##[1:60] menu_state == MS_HOME; endproperty
   a_end: assert property (p_end) else $error("end message stuck");
   property p_sel; $changed(menu_state) && menu_state == MS_SELECT |-> $past(menu_state) == MS_HOME; endproperty
   a_sel: assert property (p_sel) else $error("bad menu entry");
   property p_rng; loop_tenth_ma == 8'h1e || loop_tenth_ma inside {[8'h28:8'ha0 + 8'h28]}; endproperty
   a_rng: assert property (p_rng) else $error("loop out of range");
   property p_base; loop_tenth_ma != 8'h1e |-> tst; endproperty
   a_base: assert property (p_base) else $error("loop forced outside test");
   property p_trb; trouble_relay_test |-> tst; endproperty
   a_trb: assert property (p_trb) else $error("trouble test outside test");
   property p_alm; alarm_relay_test |-> tst; endproperty
   a_alm: assert property (p_alm) else $error("alarm test outside test");
   property p_mnt; maint_cal_in |-> !maint_cal_out && menu_state == MS_MNT_IN; endproperty
   a_mnt: assert property (p_mnt) else $error("bad calibration pick");
   c_end: cover property (menu_state == MS_END);
   c_trb: cover property (trouble_relay_test);
   c_alm: cover property (alarm_relay_test);
endmodule : dom_props

// file: tb.sv
// Purpose: Self-checking bench for the menu block
// Assumes: Short counts set at the instance
// Notes:   Keys come from the operator model
`timescale 1ns/100ps
module tb;
   import dom_pkg::*;
   logic clk = 0, reset = 1, go = 0, we_i = 0, cyc_i = 0, stb_i = 0, busy, e, under_mark, ack_o, err_o;
   logic trouble_relay_test, alarm_relay_test, checkup_active, maint_cal_in, maint_cal_out, checkup_start = 0;
   logic [1:0] k = 0, parity_item;
   logic [3:0] keys, sel_i = 0;
   logic [4:0] menu_state;
   logic [7:0] adr_i = 0, station_number, loop_tenth_ma;
   logic [15:0] segment_display, alarm_value, sensor_value = 16'hff00, sensor_raw = 16'h1234, high_scale = 16'h3e8;
   logic [31:0] dat_o, q, dat_i = 0;
   int bad_count = 0, tests_run = 0, n;
   always #12.5 clk = ~clk;
   dom_op i_dom_op (.clk(clk), .go(go), .k(k), .keys(keys), .busy(busy));
   dom_menu #(.DEB_CYC(4), .IDLE_LIM(200), .END_LIM(50), .CHK_LIM(300)) i_dom_menu (.*, .confirm_key(keys[0]),
      .up_key(keys[1]), .down_key(keys[2]), .reset_key(keys[3]));
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x)
      begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   // Classic single cycle, held until ack or err
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d = 32'h0);
      @(posedge clk);
      adr_i <= a;
      we_i  <= w;
      dat_i <= d;
      sel_i <= 4'hf;
      {cyc_i, stb_i} <= 2'h3;
      n = 0;
      do @(posedge clk); while (ack_o !== 1'b1 && err_o !== 1'b1 && ++n < 20);
      q = dat_o;
      e = err_o;
      {cyc_i, stb_i} <= 2'h0;
      chk(n < 20, 1'b1);
   endtask : wb
   // Keys: c confirm, u up, d down, r reset
   task automatic seq(input string s);
      foreach (s[i])
      begin
         k  <= (s[i] == "u") ? 2'h1 : (s[i] == "d") ? 2'h2 : (s[i] == "r") ? 2'h3 : 2'h0;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         n = 0;
         do @(posedge clk); while (busy && ++n < 40);
         chk(busy, 1'b0);
      end
   endtask : seq
   task automatic home(input int lim);
      n = 0;
      while (menu_state !== MS_HOME && n++ < lim) @(posedge clk);
      chk(menu_state, MS_HOME);
   endtask : home
   initial
   begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      chk({station_number, parity_item, under_mark, loop_tenth_ma}, {8'h01, 2'h1, 1'b0, 8'h1e});
      wb(8'h20, 1'b0);
      chk(e, 1'b1);
      wb(8'h0c, 1'b1);
      wb(8'h10, 1'b0);
      chk(q[8], 1'b1);
      seq("cuuccu");
      chk(menu_state, MS_SER_STATION);
      seq("cdc");
      chk({station_number, parity_item}, {8'h02, 2'h0});
      home(60);
      wb(8'h0c, 1'b1);
      seq("cdcccuc");
      chk(trouble_relay_test, 1'b1);
      seq("uc");
      chk({alarm_relay_test, loop_tenth_ma}, {1'b1, 8'h1e});
      seq("ucd");
      chk(loop_tenth_ma, 8'hc6);
      seq("r");
      chk(menu_state, MS_TST_HEAD);
      home(260);
      chk(trouble_relay_test, 1'b0);
      wb(8'h0c, 1'b1);
      seq("cdcccucccc");
      home(60);
      chk(under_mark, 1'b1);
      sensor_value <= 16'h0010;
      wb(8'h00, 1'b1, 32'h00141407);
      wb(8'h00, 1'b0);
      chk(q, 32'h00141407);
      chk({alarm_value, segment_display}, {16'h0000, 16'h1234});
      sensor_value <= 16'h0320;
      checkup_start <= 1'b1;
      @(posedge clk);
      checkup_start <= 1'b0;
      @(posedge clk);
      chk({checkup_active, alarm_value}, {1'b1, 16'h03e8});
      repeat (300) @(posedge clk);
      chk(checkup_active, 1'b0);
      wb(8'h0c, 1'b1);
      seq("cdcuc");
      chk({maint_cal_in, maint_cal_out}, 2'h1);
      end_sim;
   end
endmodule : tb
bind dom_menu dom_props i_dom_props (.*);
